// File: shared/dtp_pkg.sv
// constants and types for the dual 8-bit timer pair
// assumes an axi4-lite register bus with 32-bit data and word-aligned registers
package dtp_pkg;

   // ==========================================================
   // register indices (byte address = index * 4)
   localparam logic [9:0] IDX_CMP_A  = 10'h102;
   localparam logic [9:0] IDX_CMP_B  = 10'h103;
   localparam logic [9:0] IDX_CMP_C  = 10'h10a;
   localparam logic [9:0] IDX_CMP_D  = 10'h10b;
   localparam logic [9:0] IDX_CMP_E  = 10'h112;
   localparam logic [9:0] IDX_CMP_F  = 10'h113;
   localparam logic [9:0] IDX_RUN    = 10'h100;
   localparam logic [9:0] IDX_MODE   = 10'h104;
   localparam logic [9:0] IDX_FFCR   = 10'h105;
   localparam logic [9:0] IDX_STATUS = 10'h106;

   // ==========================================================
   // field positions
   localparam int RUN_LOWER_BIT = 0;
   localparam int RUN_UPPER_BIT = 1;
   localparam int RUN_PRE_BIT   = 2;
   localparam int RUN_DBE_BIT   = 7;
   localparam int FF_TOG_EN_BIT = 2;
   localparam int FF_SEL_BIT    = 3;
   localparam int ST_FLOP_BIT   = 16;
   localparam int ST_INHIB_BIT  = 17;

   // ==========================================================
   // reset values
   localparam logic [7:0] RUN_RST  = 8'h00;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [1:0] FFEN_RST = 2'h0;

   // ==========================================================
   // codes
   localparam logic [1:0] OPM_SPLIT = 2'h0;
   localparam logic [1:0] OPM_CASC  = 2'h1;
   localparam logic [1:0] OPM_PULSE = 2'h2;
   localparam logic [1:0] OPM_PWM   = 2'h3;

   localparam logic [1:0] LCLK_EXT  = 2'h0;
   localparam logic [1:0] LCLK_T1   = 2'h1;
   localparam logic [1:0] LCLK_T4   = 2'h2;
   localparam logic [1:0] UCLK_MTCH = 2'h0;
   localparam logic [1:0] UCLK_T1   = 2'h1;
   localparam logic [1:0] UCLK_T16  = 2'h2;

   localparam logic [1:0] PWM_N6    = 2'h1;
   localparam logic [1:0] PWM_N7    = 2'h2;
   localparam logic [8:0] PWM_TOP6  = 9'h040;
   localparam logic [8:0] PWM_TOP7  = 9'h080;
   localparam logic [8:0] PWM_TOP8  = 9'h100;
   localparam logic [8:0] CMP_ZERO_TOP = 9'h100;

   localparam logic [1:0] FFC_TOGGLE = 2'h0;
   localparam logic [1:0] FFC_SET    = 2'h1;
   localparam logic [1:0] FFC_CLEAR  = 2'h2;
   localparam logic [1:0] FFC_KEEP   = 2'h3;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [1:0] opmode;
      logic [1:0] pwm_period_select;
      logic [1:0] upper_clock_select;
      logic [1:0] lower_clock_select;
   } dtp_mode_s;

endpackage

// File: rtl/dtp_counter.sv
// one 8-bit up counter of the timer pair
// assumes tick and clear are single-cycle strobes in the aclk domain
`timescale 1ns/1ns
module dtp_counter #(
   parameter int W = 8
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         run,
   input  wire logic         tick,
   input  wire logic         clr,
   output logic [W-1:0]      count
);

   // ==========================================================
   // counting
   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         count <= '0;
      end else if (clr) begin
         count <= '0;
      end else if (tick) begin
         count <= count + 1'b1;
      end
   end

endmodule

// File: rtl/dtp_timer_pair.sv
// dual 8-bit timer pair with shared output flop, axi4-lite registers
// assumes external_count_input is synchronous to aclk
`timescale 1ns/1ns
// Behaviour
// - split mode: two independent 8-bit interval timers, each with match interrupt
// - lower counts external input or tap 1/4/16; upper lower-match or 1/16/256
// - split mode, toggle enabled: output flop toggles on each periodic match of the timer chosen by the select bit
// - split mode: upper may count lower compare-match pulses
// - operating mode 01 cascades both timers into one 16-bit timer
// - 16-bit mode: upper clocked by lower overflow regardless of selection
// - lower compare write inhibits the 16-bit comparison, upper compare write re-enables it
// - 16-bit mode: lower match pulses only, no clear, no lower interrupt
// - 16-bit: both match clears both counters, upper interrupt, optional toggle
// - pulse mode: lower timer makes programmable square wave; upper unavailable
// - pulse mode: output toggles on lower counter equal to either compare
// - pulse mode, double buffered: buffer loads lower compare at upper match
// - pwm only on lower timer, up to 8 bits; upper stays a timer
// - pwm: toggle at lower compare match and at 2^n overflow, n 6/7/8
// - pwm: lower counter cleared at the 2^n overflow
// - pwm, double buffered: buffer loads lower compare at each overflow
// - pulse mode waveform drives the shared timer output pin
// - 8-bit mode: match clears counter, raises interrupt, optionally toggles
// - compare value 00 matches at counter overflow, not at zero, except the upper byte in 16-bit mode
// - lower compare writes go to both registers, or buffer only when enabled
// - flop code 01 sets, 10 clears, 00 toggles; reset clears flop
module dtp_timer_pair #(
   parameter int ADDR_W = 12
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              external_count_input,
   output logic                   timer_output_pin,
   output logic                   lower_compare_match,
   output logic                   lower_match_irq,
   output logic                   upper_match_irq
);

   // ==========================================================
   // state
   logic [ADDR_W-1:0]   aw_addr_q;
   logic                aw_full_q;
   logic [31:0]         w_data_q;
   logic                w_strb0_q;
   logic                w_full_q;
   logic                bvalid_q;
   logic [1:0]          bresp_q;
   logic                rvalid_q;
   logic [31:0]         rdata_q;
   logic [1:0]          rresp_q;
   logic [7:0]          run_q;
   dtp_pkg::dtp_mode_s  mode_q;
   logic [1:0]          ffen_q;
   logic [7:0]          cmp0_q;
   logic [7:0]          buf0_q;
   logic [7:0]          cmp1_q;
   logic                inhibit_q;
   logic                flop_q;
   logic [7:0]          pre_q;
   logic                ext_q;
   logic                lmatch_q;
   logic                lirq_q;
   logic                uirq_q;
   logic [7:0]          cnt0;
   logic [7:0]          cnt1;

   // ==========================================================
   // bus slave: address and data are taken in either order
   logic                do_wr;
   logic [9:0]          wr_idx;
   logic [9:0]          rd_idx;
   logic                wr_ok;
   logic                rd_ok;
   logic                wr_cmp0;
   logic                wr_cmp1;
   logic                wr_ffcr;

   assign s_axi_awready = !aw_full_q;
   assign s_axi_wready  = !w_full_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   assign do_wr  = aw_full_q && w_full_q && !bvalid_q;
   assign wr_idx = aw_addr_q[11:2];
   assign rd_idx = s_axi_araddr[11:2];
   assign wr_ok  = wr_idx == dtp_pkg::IDX_CMP_A || wr_idx == dtp_pkg::IDX_CMP_B
                || wr_idx == dtp_pkg::IDX_RUN   || wr_idx == dtp_pkg::IDX_MODE
                || wr_idx == dtp_pkg::IDX_FFCR  || wr_idx == dtp_pkg::IDX_STATUS;
   assign rd_ok  = rd_idx == dtp_pkg::IDX_CMP_A || rd_idx == dtp_pkg::IDX_CMP_B
                || rd_idx == dtp_pkg::IDX_RUN   || rd_idx == dtp_pkg::IDX_MODE
                || rd_idx == dtp_pkg::IDX_FFCR  || rd_idx == dtp_pkg::IDX_STATUS;
   assign wr_cmp0 = do_wr && w_strb0_q && wr_idx == dtp_pkg::IDX_CMP_A;
   assign wr_cmp1 = do_wr && w_strb0_q && wr_idx == dtp_pkg::IDX_CMP_B;
   assign wr_ffcr = do_wr && w_strb0_q && wr_idx == dtp_pkg::IDX_FFCR;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         aw_addr_q <= '0;
      end else if (s_axi_awvalid && !aw_full_q) begin
         aw_full_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end else if (do_wr) begin
         aw_full_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full_q  <= 1'b0;
         w_data_q  <= 32'h0;
         w_strb0_q <= 1'b0;
      end else if (s_axi_wvalid && !w_full_q) begin
         w_full_q  <= 1'b1;
         w_data_q  <= s_axi_wdata;
         w_strb0_q <= s_axi_wstrb[0];
      end else if (do_wr) begin
         w_full_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= dtp_pkg::RESP_OKAY;
      end else if (do_wr) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_ok ? dtp_pkg::RESP_OKAY : dtp_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // compare registers are write-only and read back as zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0;
         rresp_q  <= dtp_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rresp_q  <= rd_ok ? dtp_pkg::RESP_OKAY : dtp_pkg::RESP_SLVERR;
         case (rd_idx)
            dtp_pkg::IDX_RUN:    rdata_q <= {24'h0, run_q};
            dtp_pkg::IDX_MODE:   rdata_q <= {24'h0, mode_q};
            dtp_pkg::IDX_FFCR:   rdata_q <= {28'h0, ffen_q, dtp_pkg::FFC_KEEP};
            dtp_pkg::IDX_STATUS: rdata_q <= {14'h0, inhibit_q, flop_q, cnt1, cnt0};
            default:             rdata_q <= 32'h0;
         endcase
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ==========================================================
   // control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_q <= dtp_pkg::RUN_RST;
      end else if (do_wr && w_strb0_q && wr_idx == dtp_pkg::IDX_RUN) begin
         run_q <= w_data_q[7:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_q <= dtp_pkg::MODE_RST;
      end else if (do_wr && w_strb0_q && wr_idx == dtp_pkg::IDX_MODE) begin
         mode_q <= w_data_q[7:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ffen_q <= dtp_pkg::FFEN_RST;
      end else if (wr_ffcr) begin
         ffen_q <= w_data_q[dtp_pkg::FF_SEL_BIT:dtp_pkg::FF_TOG_EN_BIT];
      end
   end

   // ==========================================================
   // clock sources: prescaler taps and external edges
   logic pre_run;
   logic t1;
   logic t4;
   logic t16;
   logic t256;
   logic ext_edge;
   assign pre_run  = run_q[dtp_pkg::RUN_PRE_BIT];
   assign t1       = pre_run;
   assign t4       = pre_run && pre_q[1:0] == 2'h3;
   assign t16      = pre_run && pre_q[3:0] == 4'hf;
   assign t256     = pre_run && pre_q == 8'hff;
   assign ext_edge = external_count_input && !ext_q;

   always_ff @(posedge aclk) begin
      if (!aresetn || !pre_run) begin
         pre_q <= 8'h00;
      end else begin
         pre_q <= pre_q + 8'h01;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_q <= 1'b0;
      end else begin
         ext_q <= external_count_input;
      end
   end

   // ==========================================================
   // comparators and mode decode
   logic       is_split;
   logic       is_casc;
   logic       is_pulse;
   logic       is_pwm;
   logic       tick0;
   logic       tick1;
   logic [8:0] nxt0;
   logic [8:0] nxt1;
   logic [8:0] tgt0;
   logic [8:0] tgt1;
   logic [8:0] pwm_top;
   logic       hit0;
   logic       hit0u;
   logic       hit1;
   logic       ovf8;
   logic       m16;
   logic       ovf_pwm;
   logic       clr0;
   logic       clr1;
   logic       ev_irq0;
   logic       ev_irq1;
   logic       hw_tog;
   logic       db_load;
   logic       dbe;
   logic       tog_en;

   assign is_split = mode_q.opmode == dtp_pkg::OPM_SPLIT;
   assign is_casc  = mode_q.opmode == dtp_pkg::OPM_CASC;
   assign is_pulse = mode_q.opmode == dtp_pkg::OPM_PULSE;
   assign is_pwm   = mode_q.opmode == dtp_pkg::OPM_PWM;
   assign dbe      = run_q[dtp_pkg::RUN_DBE_BIT];
   assign tog_en   = ffen_q[0];

   always_comb begin
      case (mode_q.lower_clock_select)
         dtp_pkg::LCLK_EXT: tick0 = ext_edge;
         dtp_pkg::LCLK_T1:  tick0 = t1;
         dtp_pkg::LCLK_T4:  tick0 = t4;
         default:           tick0 = t16;
      endcase
   end

   assign nxt0 = {1'b0, cnt0} + 9'h001;
   assign nxt1 = {1'b0, cnt1} + 9'h001;
   // a compare value of zero stands for a full 256-count wrap
   assign tgt0 = (cmp0_q == 8'h00) ? dtp_pkg::CMP_ZERO_TOP : {1'b0, cmp0_q};
   assign tgt1 = (cmp1_q == 8'h00) ? dtp_pkg::CMP_ZERO_TOP : {1'b0, cmp1_q};
   assign hit0  = tick0 && nxt0 == tgt0;
   assign hit0u = tick0 && nxt0 == tgt1;
   assign ovf8  = tick0 && cnt0 == 8'hff;

   always_comb begin
      if (is_casc) begin
         tick1 = ovf8;
      end else if (is_pulse) begin
         tick1 = 1'b0;
      end else begin
         case (mode_q.upper_clock_select)
            dtp_pkg::UCLK_MTCH: tick1 = hit0;
            dtp_pkg::UCLK_T1:   tick1 = t1;
            dtp_pkg::UCLK_T16:  tick1 = t16;
            default:            tick1 = t256;
         endcase
      end
   end

   assign hit1 = tick1 && nxt1 == tgt1;
   // the upper byte is still mid-count until its own compare is reached
   assign m16  = hit0 && !inhibit_q && cnt1 == cmp1_q;

   always_comb begin
      case (mode_q.pwm_period_select)
         dtp_pkg::PWM_N6: pwm_top = dtp_pkg::PWM_TOP6;
         dtp_pkg::PWM_N7: pwm_top = dtp_pkg::PWM_TOP7;
         default:         pwm_top = dtp_pkg::PWM_TOP8;
      endcase
   end
   assign ovf_pwm = tick0 && nxt0 == pwm_top;

   always_comb begin
      clr0    = 1'b0;
      clr1    = 1'b0;
      ev_irq0 = 1'b0;
      ev_irq1 = 1'b0;
      hw_tog  = 1'b0;
      db_load = 1'b0;
      if (is_split) begin
         clr0    = hit0;
         clr1    = hit1;
         ev_irq0 = hit0;
         ev_irq1 = hit1;
         hw_tog  = tog_en && (ffen_q[1] ? hit1 : hit0);
      end else if (is_casc) begin
         clr0    = m16;
         clr1    = m16;
         ev_irq1 = m16;
         hw_tog  = tog_en && m16;
      end else if (is_pulse) begin
         clr0    = hit0u;
         ev_irq0 = hit0;
         ev_irq1 = hit0u;
         hw_tog  = hit0 || hit0u;
         db_load = dbe && hit0u;
      end else begin
         clr0    = ovf_pwm;
         clr1    = hit1;
         ev_irq0 = ovf_pwm;
         ev_irq1 = hit1;
         hw_tog  = hit0 || ovf_pwm;
         db_load = dbe && ovf_pwm;
      end
   end

   // ==========================================================
   // counters
   dtp_counter #(.W(8)) u_lower_up_counter (
      .aclk    (aclk),
      .aresetn (aresetn),
      .run     (run_q[dtp_pkg::RUN_LOWER_BIT]),
      .tick    (tick0),
      .clr     (clr0),
      .count   (cnt0)
   );

   dtp_counter #(.W(8)) u_upper_up_counter (
      .aclk    (aclk),
      .aresetn (aresetn),
      .run     (run_q[dtp_pkg::RUN_UPPER_BIT]),
      .tick    (tick1),
      .clr     (clr1),
      .count   (cnt1)
   );

   // ==========================================================
   // compare registers; contents undefined until written, so reset leaves them
   always_ff @(posedge aclk) begin
      if (wr_cmp0) begin
         buf0_q <= w_data_q[7:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (wr_cmp0 && !dbe) begin
         cmp0_q <= w_data_q[7:0];
      end else if (db_load) begin
         cmp0_q <= buf0_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (wr_cmp1) begin
         cmp1_q <= w_data_q[7:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         inhibit_q <= 1'b0;
      end else if (wr_cmp0) begin
         inhibit_q <= 1'b1;
      end else if (wr_cmp1) begin
         inhibit_q <= 1'b0;
      end
   end

   // ==========================================================
   // output flop; software set or clear overrides a hardware toggle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flop_q <= 1'b0;
      end else if (wr_ffcr && w_data_q[1:0] == dtp_pkg::FFC_SET) begin
         flop_q <= 1'b1;
      end else if (wr_ffcr && w_data_q[1:0] == dtp_pkg::FFC_CLEAR) begin
         flop_q <= 1'b0;
      end else begin
         flop_q <= flop_q ^ hw_tog ^ (wr_ffcr && w_data_q[1:0] == dtp_pkg::FFC_TOGGLE);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lmatch_q <= 1'b0;
         lirq_q   <= 1'b0;
         uirq_q   <= 1'b0;
      end else begin
         lmatch_q <= hit0;
         lirq_q   <= ev_irq0;
         uirq_q   <= ev_irq1;
      end
   end

   assign timer_output_pin    = flop_q;
   assign lower_compare_match = lmatch_q;
   assign lower_match_irq     = lirq_q;
   assign upper_match_irq     = uirq_q;

   // ==========================================================
   // assertions
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_stop_zero;
      !run_q[dtp_pkg::RUN_LOWER_BIT] |=> cnt0 == 8'h00;
   endproperty
   a_stop_zero: assert property (p_stop_zero) else $error("stopped counter not zero");

   property p_advance;
      run_q[dtp_pkg::RUN_LOWER_BIT] && tick0 && !clr0 |=> cnt0 == $past(cnt0) + 8'h01;
   endproperty
   a_advance: assert property (p_advance) else $error("counter did not advance");

   property p_split_match;
      is_split && hit0 && run_q[dtp_pkg::RUN_LOWER_BIT] |=> cnt0 == 8'h00 && lower_match_irq;
   endproperty
   a_split_match: assert property (p_split_match) else $error("split match missed");

   property p_casc_no_lirq;
      is_casc ##1 is_casc |-> !lower_match_irq;
   endproperty
   a_casc_no_lirq: assert property (p_casc_no_lirq) else $error("lower irq in 16-bit");

   property p_casc_both;
      is_casc && m16 |=> cnt0 == 8'h00 && cnt1 == 8'h00 && upper_match_irq;
   endproperty
   a_casc_both: assert property (p_casc_both) else $error("16-bit match wrong");

   property p_toggle;
      hw_tog && !wr_ffcr |=> timer_output_pin != $past(timer_output_pin);
   endproperty
   a_toggle: assert property (p_toggle) else $error("flop did not toggle");

   property p_ff_set;
      wr_ffcr && w_data_q[1:0] == dtp_pkg::FFC_SET |=> timer_output_pin;
   endproperty
   a_ff_set: assert property (p_ff_set) else $error("flop set failed");

   property p_pwm_clear;
      is_pwm && ovf_pwm && run_q[dtp_pkg::RUN_LOWER_BIT] |=> cnt0 == 8'h00;
   endproperty
   a_pwm_clear: assert property (p_pwm_clear) else $error("pwm overflow no clear");

   property p_pwm_load;
      is_pwm && dbe && ovf_pwm && !wr_cmp0 |=> cmp0_q == $past(buf0_q);
   endproperty
   a_pwm_load: assert property (p_pwm_load) else $error("pwm buffer not loaded");

   property p_inhibit;
      wr_cmp0 |=> inhibit_q ##1 (inhibit_q || $past(wr_cmp1));
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("inhibit not held");

   c_casc_match: cover property (is_casc && m16);
   c_pulse_cycle: cover property (is_pulse && hit0u && dbe);
   c_pwm_ovf:    cover property (is_pwm && ovf_pwm);
   c_split_chain: cover property (is_split && tick1 && mode_q.upper_clock_select == 2'h0);

endmodule

// File: sim/dtp_pin_model.sv
// far side of the timer pins: a pulse source on the external count input
// assumes the bench leaves it running; only the external clock selection sees it
`timescale 1ns/1ns
module dtp_pin_model (
   input  wire logic aclk,
   input  wire logic en,
   output logic      ext_q = 1'b0
);
   // ==========================================
   // pulse generator
   logic [1:0] ph_q = 2'h0;
   // one high cycle in four: a rising edge every 4 cycles, never two in a row
   always_ff @(posedge aclk) begin
      ph_q  <= en ? ph_q + 2'h1 : 2'h0;
      ext_q <= en && (ph_q == 2'h3);
   end
endmodule

// File: sim/tb_top.sv
// self-checking bench for the timer pair over axi4-lite
// assumes the byte address of a register is four times its index
`timescale 1ns/1ns
module tb_top;
   // ==========================================
   // signals
   logic        aclk = 1'b0, aresetn = 1'b0, ext_en = 1'b1;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        external_count_input, timer_output_pin, lower_compare_match;
   logic        lower_match_irq, upper_match_irq;
   int          n_mismatch = 0, compares = 0, cyc = 0, n_li, n_tg, n_lm, n_at;

   dtp_timer_pair dtp_timer_pair_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .external_count_input, .timer_output_pin, .lower_compare_match,
      .lower_match_irq, .upper_match_irq);
   dtp_pin_model dtp_pin_model_i (.aclk(aclk), .en(ext_en), .ext_q(external_count_input));

   always #4 aclk = ~aclk;

   // ==========================================
   // reporting
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // ==========================================
   // bus tasks: readies sampled at the falling edge, released after the taking edge
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
      logic ta, tw, tb;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      #1;
      while (s_axi_awvalid || s_axi_wvalid || s_axi_bready) begin
         @(negedge aclk);
         ta = s_axi_awready;
         tw = s_axi_wready;
         tb = s_axi_bvalid;
         if (tb) chk({30'h0, s_axi_bresp}, {30'h0, r}, "bresp");
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb) s_axi_bready <= 1'b0;
         #1;
      end
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
      logic ta, tb;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      #1;
      while (s_axi_arvalid || s_axi_rready) begin
         @(negedge aclk);
         ta = s_axi_arready;
         tb = s_axi_rvalid;
         if (tb) chk(s_axi_rdata, e, "rdata");
         if (tb) chk({30'h0, s_axi_rresp}, {30'h0, r}, "rresp");
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
         if (tb) s_axi_rready <= 1'b0;
         #1;
      end
   endtask

   // ==========================================
   // interval between two pulses, with flop toggles and lower interrupts seen meanwhile
   function automatic logic pick(input int w);
      return (w == 0) ? lower_match_irq : upper_match_irq;
   endfunction

   task automatic gap(input int w, input int e, input int tg);
      int   n;
      logic p;
      n = 0;
      while (pick(w) !== 1'b1) @(negedge aclk);
      n_li = 0;
      n_tg = 0;
      n_lm = 0;
      n_at = 0;
      p = timer_output_pin;
      do begin
         @(negedge aclk);
         n++;
         if (lower_match_irq === 1'b1) n_li++;
         if (lower_compare_match === 1'b1) begin
            n_lm++;
            n_at = n;
         end
         if (timer_output_pin !== p) n_tg++;
         p = timer_output_pin;
      end while (pick(w) !== 1'b1);
      chk(n, e, "interval");
      if (tg >= 0) chk(n_tg, tg, "toggles");
   endtask

   // counters stop before any mode or compare change, lower compare first
   task automatic run(input logic [7:0] m, a, b, input int w, e, tg);
      wr(12'h400, 8'h00, 2'h0);
      wr(12'h410, m, 2'h0);
      wr(12'h408, a, 2'h0);
      wr(12'h40c, b, 2'h0);
      wr(12'h400, 8'h07, 2'h0);
      gap(w, e, tg);
   endtask

   // ==========================================
   // main sequence
   logic [7:0] cod [3] = '{8'h01, 8'h02, 8'h00};
   logic       flp [3] = '{1'b1, 1'b0, 1'b1};
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(12'h418, 32'h0, 2'h0);
      rd(12'h408, 32'h0, 2'h0);
      wr(12'h428, 8'h5a, 2'h2);
      rd(12'h428, 32'h0, 2'h2);
      for (int i = 0; i < 3; i++) begin
         wr(12'h414, cod[i], 2'h0);
         rd(12'h418, {15'h0, flp[i], 16'h0}, 2'h0);
      end
      wr(12'h408, 8'h03, 2'h0);
      rd(12'h418, 32'h30000, 2'h0);
      wr(12'h40c, 8'h02, 2'h0);
      rd(12'h418, 32'h10000, 2'h0);
      wr(12'h414, 8'h07, 2'h0);
      run(8'h01, 8'h03, 8'h02, 0, 3, 1);
      run(8'h01, 8'h03, 8'h02, 1, 6, 2);
      run(8'h02, 8'h03, 8'h02, 0, 12, 1);
      run(8'h03, 8'h03, 8'h02, 0, 48, 1);
      run(8'h00, 8'h04, 8'h02, 0, 16, 1);
      run(8'h05, 8'h03, 8'h02, 1, 2, -1);
      run(8'h09, 8'h03, 8'h02, 1, 32, -1);
      run(8'h0d, 8'h03, 8'h02, 1, 512, -1);
      run(8'h03, 8'h00, 8'h02, 0, 4096, 1);
      run(8'h4d, 8'h02, 8'h01, 1, 258, 1);
      chk(n_li, 0, "lower irq in 16-bit");
      chk(n_lm, 2, "lower match in 16-bit");
      run(8'h81, 8'h04, 8'h0a, 1, 10, 2);
      // double buffer on while running: only the buffer takes the new compare
      wr(12'h400, 8'h87, 2'h0);
      wr(12'h408, 8'h06, 2'h0);
      gap(1, 10, 2);
      chk(n_at, 6, "pulse buffer load");
      run(8'hd1, 8'h10, 8'h02, 0, 64, 2);
      wr(12'h400, 8'h87, 2'h0);
      wr(12'h408, 8'h20, 2'h0);
      gap(0, 64, 2);
      chk(n_at, 32, "pwm buffer load");
      give_verdict();
   end
endmodule
